// ===== logic/vsptc_top.sv
// Purpose: Sync reference pins, trigger phases and subcarrier phase reset.
// Assumes: Register port is the subaddress side of the serial control bus.
// Notes:   Timing runs on the pixel clock i_clk.
// Summary of operation
// - Second pin polarity: 0 high/rising, 1 low/falling.
// - Second pin direction: 0 input, 1 output.
// - Output, blanking select 0: horizontal reference pulse.
// - Output, blanking select 1: pulse without vertical blanking.
// - Input, select 0: horizontal sync only.
// - Input, select 1: also internal blanking.
// - First pin polarity: 0 high/rising, 1 low/falling.
// - First pin direction: 0 input, 1 output.
// - Horizontal source: first pin, embedded, or second.
// - First pin type: field, frame, sequence, invalid.
// - Field sequence every fourth or eighth field.
// - Horizontal phase presets counter; 398H aligns sync.
// - Vertical phase advances timing in half lines.
// - Blanking from active lines or forced standard.
// - Phase reset every two lines, eight, four fields.
// - Mode 00 resets phase only via real-time input.
// - Line length 864 or 858 pixel clocks.
// - Colour standard selects alternating V component.
// - Real-time enable gates the real-time input.
// - Field length interlaced, short or long.
`timescale 1ns/1ns
`default_nettype none
module vsptc_top
  import vsptc_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [7:0]  i_reg_wdata,
  output logic      [7:0]  o_reg_rdata,
  input  wire logic        i_line_length_select,
  input  wire logic        i_colour_standard_bit,
  input  wire logic        i_realtime_control_enable,
  input  wire logic        i_realtime_control_input,
  input  wire logic        i_embedded_sync_select,
  input  wire logic        i_embedded_hsync,
  input  wire logic [10:0] i_reference_pulse_start,
  input  wire logic [10:0] i_reference_pulse_end,
  input  wire logic [8:0]  i_first_active_line,
  input  wire logic [8:0]  i_last_active_line,
  input  wire logic        i_first_reference_pin,
  output logic             o_first_reference_pin,
  output logic             o_first_reference_pin_oe,
  input  wire logic        i_second_reference_pin,
  output logic             o_second_reference_pin,
  output logic             o_second_reference_pin_oe,
  output logic             o_hsync,
  output logic             o_internal_blank,
  output logic             o_sc_phase_reset,
  output logic             o_v_alternate,
  output logic             o_odd_field
);
  ////////////////////////////////////////////////////////////////////////
  logic [7:0] ctrl_r, htl_r, trh_r, bp_r, rdata_r;
  logic [7:0] ctrl_nxt, htl_nxt, trh_nxt, bp_nxt, rdata_nxt;

  // Register writes and registered read data.
  always_comb begin
    ctrl_nxt  = ctrl_r;
    htl_nxt   = htl_r;
    trh_nxt   = trh_r;
    bp_nxt    = bp_r;
    rdata_nxt = rdata_r;
    if (i_reg_wr) begin
      unique case (i_reg_addr)
        VSPTC_ADDR_PIN_CTRL: ctrl_nxt = i_reg_wdata;
        VSPTC_ADDR_HORIZONTAL_TRIGGER_PHASE_LO: htl_nxt  = i_reg_wdata;
        VSPTC_ADDR_TRIG_HI:  trh_nxt  = i_reg_wdata;
        VSPTC_ADDR_BLK_PHS:  bp_nxt   = i_reg_wdata;
        default: ;
      endcase
    end
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        VSPTC_ADDR_PIN_CTRL: rdata_nxt = ctrl_r;
        VSPTC_ADDR_HORIZONTAL_TRIGGER_PHASE_LO: rdata_nxt = htl_r;
        VSPTC_ADDR_TRIG_HI:  rdata_nxt = trh_r;
        VSPTC_ADDR_BLK_PHS:  rdata_nxt = bp_r;
        default:             rdata_nxt = VSPTC_UNMAPPED_DATA;
      endcase
    end
  end

  // Register storage; all fields reset to zero.
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ctrl_r  <= VSPTC_RESET_VALUE;
      htl_r   <= VSPTC_RESET_VALUE;
      trh_r   <= VSPTC_RESET_VALUE;
      bp_r    <= VSPTC_RESET_VALUE;
      rdata_r <= VSPTC_RESET_VALUE;
    end else begin
      ctrl_r  <= ctrl_nxt;
      htl_r   <= htl_nxt;
      trh_r   <= trh_nxt;
      bp_r    <= bp_nxt;
      rdata_r <= rdata_nxt;
    end
  end
  assign o_reg_rdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////
  // Field decode.
  logic               hpol, hdir, blanking_pulse_select, vpol, vdir, hsrc, blanking_standard_force;
  logic [10:0]        horizontal_trigger_phase;
  logic [4:0]         vertical_trigger_phase;
  logic [1:0]         field_length_control;
  vsptc_pin_type_type vtype;
  vsptc_phr_type      phr;
  assign hpol  = ctrl_r[VSPTC_HPOL_BIT];
  assign hdir  = ctrl_r[VSPTC_HDIR_BIT];
  assign blanking_pulse_select  = ctrl_r[VSPTC_BLANKING_PULSE_SELECT_BIT];
  assign vpol  = ctrl_r[VSPTC_VPOL_BIT];
  assign vdir  = ctrl_r[VSPTC_VDIR_BIT];
  assign hsrc  = ctrl_r[VSPTC_HSRC_BIT];
  assign vtype = vsptc_pin_type_type'(ctrl_r[VSPTC_VTYPE_LSB +: 2]);
  assign horizontal_trigger_phase = {trh_r[VSPTC_HORIZONTAL_TRIGGER_PHASE_HI_LSB +: 3], htl_r};
  assign vertical_trigger_phase = trh_r[VSPTC_VERTICAL_TRIGGER_PHASE_LSB +: 5];
  assign blanking_standard_force = bp_r[VSPTC_BLANKING_STANDARD_FORCE_BIT];
  assign phr   = vsptc_phr_type'(bp_r[VSPTC_SUBCARRIER_PHASE_RESET_MODE_LSB +: 2]);
  assign field_length_control   = bp_r[VSPTC_FLC_LSB +: 2];

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; polarity-selected active edge on the reference pins, rising edge on the real-time input.
  logic v_lvl, v_pin_edge, h_lvl, h_pin_edge, rtc_lvl, rtc_edge;
  vsptc_ref_edge u_vref (
    .i_clk    (i_clk),
    .i_reset  (i_reset),
    .i_pin    (i_first_reference_pin),
    .i_invert (vpol),
    .o_level  (v_lvl),
    .o_edge   (v_pin_edge)
  );
  vsptc_ref_edge u_href (
    .i_clk    (i_clk),
    .i_reset  (i_reset),
    .i_pin    (i_second_reference_pin),
    .i_invert (hpol),
    .o_level  (h_lvl),
    .o_edge   (h_pin_edge)
  );
  vsptc_ref_edge u_rtc (
    .i_clk    (i_clk),
    .i_reset  (i_reset),
    .i_pin    (i_realtime_control_input),
    .i_invert (1'b0),
    .o_level  (rtc_lvl),
    .o_edge   (rtc_edge)
  );

  ////////////////////////////////////////////////////////////////////////
  // Trigger selection; edges from a pin count only while it is an input.
  logic h_edge, v_edge;
  always_comb begin
    if (i_embedded_sync_select)
      h_edge = i_embedded_hsync;
    else if (hsrc)
      h_edge = h_pin_edge & ~hdir;
    else
      h_edge = v_pin_edge & ~vdir;
    v_edge = v_pin_edge & ~vdir & (vtype != VSPTC_TYPE_BAD);
  end

  // Line and field length selection.
  logic [10:0] line_last, half_last;
  logic [9:0]  field_last;
  logic [8:0]  fal_eff, lal_eff;
  always_comb begin
    logic [9:0] hl;
    hl = VSPTC_HL50_I;
    if (i_line_length_select) begin
      line_last = {VSPTC_LINE_858[9:0], 1'b0} - 11'h002;
      half_last = {1'b0, VSPTC_LINE_858[10:1]};
      unique case (field_length_control)
        2'b00:   hl = VSPTC_HL60_I;
        2'b01:   hl = VSPTC_HL60_S;
        default: hl = VSPTC_HL60_L;
      endcase
      fal_eff = VSPTC_STD60_FIRST;
      lal_eff = VSPTC_STD60_LAST;
    end else begin
      line_last = {VSPTC_LINE_864[9:0], 1'b0} - 11'h002;
      half_last = {1'b0, VSPTC_LINE_864[10:1]};
      unique case (field_length_control)
        2'b00:   hl = VSPTC_HL50_I;
        2'b01:   hl = VSPTC_HL50_S;
        default: hl = VSPTC_HL50_L;
      endcase
      fal_eff = VSPTC_STD50_FIRST;
      lal_eff = VSPTC_STD50_LAST;
    end
    if (!blanking_standard_force) begin
      fal_eff = i_first_active_line;
      lal_eff = i_last_active_line;
    end
    field_last = hl - 10'h001;
  end

  ////////////////////////////////////////////////////////////////////////
  // Timing counters: pixel, half line, field and line parity.
  logic [10:0] h_cnt_r, h_cnt_nxt;
  logic [9:0]  vh_cnt_r, vh_cnt_nxt;
  logic [2:0]  fld_r, fld_nxt;
  logic        par_r, par_nxt;
  logic        line_start, half_tick, field_end;
  always_comb begin
    // Positions are half pixels, two per clock, so a line of 864 clocks
    // spans 0 to 1727; a phase value past the line end wraps at the next clock.
    line_start = (h_cnt_r >= line_last);
    half_tick  = line_start | ({1'b0, h_cnt_r[10:1]} == half_last);
    field_end  = half_tick & (vh_cnt_r >= field_last);
    h_cnt_nxt  = line_start ? h_cnt_r - line_last : h_cnt_r + 11'h002;
    vh_cnt_nxt = vh_cnt_r;
    fld_nxt    = fld_r;
    par_nxt    = par_r ^ line_start;
    if (half_tick)
      vh_cnt_nxt = field_end ? 10'h000 : vh_cnt_r + 10'h001;
    if (field_end)
      fld_nxt = fld_r + 3'h1;
    // Larger phase values preset further on, so events come sooner.
    if (h_edge)
      h_cnt_nxt = horizontal_trigger_phase;
    if (v_edge) begin
      vh_cnt_nxt = {5'h00, vertical_trigger_phase};
      if (vtype != VSPTC_PER_FIELD_VS)
        fld_nxt = 3'h0;
    end
  end

  // Timing counter registers.
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      h_cnt_r  <= 11'h000;
      vh_cnt_r <= 10'h000;
      fld_r    <= 3'h0;
      par_r    <= 1'b0;
    end else begin
      h_cnt_r  <= h_cnt_nxt;
      vh_cnt_r <= vh_cnt_nxt;
      fld_r    <= fld_nxt;
      par_r    <= par_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Generated sync, blanking and phase reset, all registered.
  logic [8:0] line;
  logic       href, vblank, vs_act, p1_act, p2_act, phr_nxt;
  logic       o1_r, o2_r, hs_r, blk_r, phr_r, va_r;
  logic       o1_nxt, o2_nxt, hs_nxt, blk_nxt, va_nxt;
  always_comb begin
    line   = vh_cnt_r[9:1];
    href   = (h_cnt_r >= i_reference_pulse_start) &&
             (h_cnt_r < i_reference_pulse_end);
    vblank = (line < fal_eff) || (line > lal_eff);
    vs_act = (vh_cnt_r < VSPTC_VS_HALF);
    unique case (vtype)
      VSPTC_PER_FIELD_VS: p1_act = vs_act;
      VSPTC_ODD_EVEN_FS:  p1_act = ~fld_r[0];
      VSPTC_FIELD_SEQ:    p1_act = vs_act & (i_colour_standard_bit ?
                            (fld_r == 3'h0) : (fld_r[1:0] == 2'h0));
      VSPTC_TYPE_BAD:     p1_act = 1'b0;
    endcase
    p2_act = blanking_pulse_select ? (href & ~vblank) : href;
    o1_nxt = p1_act ^ vpol;
    o2_nxt = p2_act ^ hpol;
    hs_nxt = (h_cnt_r >= VSPTC_HSYNC_REF) &&
             (h_cnt_r < VSPTC_HSYNC_REF + VSPTC_HSYNC_LEN);
    if (!hdir && !i_embedded_sync_select && blanking_pulse_select)
      blk_nxt = ~h_lvl;
    else
      blk_nxt = vblank | ~href;
    unique case (phr)
      VSPTC_PHR_RTC:   phr_nxt = i_realtime_control_enable &
                                 rtc_edge;
      VSPTC_PHR_2LINE: phr_nxt = line_start & par_r;
      VSPTC_PHR_8FLD:  phr_nxt = field_end & (fld_nxt == 3'h0);
      VSPTC_PHR_4FLD:  phr_nxt = field_end &
                                 (fld_nxt[1:0] == 2'h0);
    endcase
    va_nxt = i_colour_standard_bit & par_r;
  end

  // Output registers.
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o1_r  <= 1'b0;
      o2_r  <= 1'b0;
      hs_r  <= 1'b0;
      blk_r <= 1'b1;
      phr_r <= 1'b0;
      va_r  <= 1'b0;
    end else begin
      o1_r  <= o1_nxt;
      o2_r  <= o2_nxt;
      hs_r  <= hs_nxt;
      blk_r <= blk_nxt;
      phr_r <= phr_nxt;
      va_r  <= va_nxt;
    end
  end

  // Drivers stay off while a pin is an input.
  assign o_first_reference_pin     = o1_r;
  assign o_first_reference_pin_oe  = vdir;
  assign o_second_reference_pin    = o2_r;
  assign o_second_reference_pin_oe = hdir;
  assign o_hsync          = hs_r;
  assign o_internal_blank = blk_r;
  assign o_sc_phase_reset = phr_r;
  assign o_v_alternate    = va_r;
  assign o_odd_field      = ~fld_r[0];

  ////////////////////////////////////////////////////////////////////////
  // Checks on the generated timing.
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);

  sequence quiet_run;
    !o_sc_phase_reset [*8];
  endsequence

  vdir_write_a: assert property (
    i_reg_wr && i_reg_addr == VSPTC_ADDR_PIN_CTRL &&
    !i_reg_wdata[VSPTC_VDIR_BIT] |=> !o_first_reference_pin_oe)
    else $error("First pin driven after set to input.");
  hdir_write_a: assert property (
    i_reg_wr && i_reg_addr == VSPTC_ADDR_PIN_CTRL &&
    !i_reg_wdata[VSPTC_HDIR_BIT] |=> !o_second_reference_pin_oe)
    else $error("Second pin driven after set to input.");
  horizontal_trigger_phase_preset_a: assert property (
    h_edge |=> h_cnt_r == $past(horizontal_trigger_phase))
    else $error("Pixel counter not preset to trigger phase.");
  line_wrap_a: assert property (
    h_cnt_r == line_last && !h_edge |=> h_cnt_r == 11'h000)
    else $error("Line did not wrap at its length.");
  vertical_trigger_phase_preset_a: assert property (
    v_edge |=> vh_cnt_r == {5'h00, $past(vertical_trigger_phase)})
    else $error("Half line counter not preset to phase.");
  href_out_a: assert property (
    hdir && !blanking_pulse_select && href && $stable(hpol) |=>
    o_second_reference_pin == !$past(hpol))
    else $error("Reference pulse missing on second pin.");
  cblank_out_a: assert property (
    blanking_pulse_select && vblank && $stable(hpol) |=>
    o_second_reference_pin == $past(hpol))
    else $error("Pulse present in vertical blanking.");
  two_line_a: assert property (
    o_sc_phase_reset && phr == VSPTC_PHR_2LINE &&
    $stable(bp_r) |=> quiet_run)
    else $error("Phase reset repeated within a line pair.");
  no_rtc_a: assert property (
    phr == VSPTC_PHR_RTC && !i_realtime_control_enable &&
    $past(phr == VSPTC_PHR_RTC && !i_realtime_control_enable) |->
    !o_sc_phase_reset)
    else $error("Phase reset without enabled real-time input.");
endmodule
`default_nettype wire

// ===== logic/vsptc_pkg.sv
// Purpose: Shared constants for the sync reference pin and trigger block.
// Assumes: 8-bit subaddressed registers behind the serial control bus.
// Notes:   Bit positions are within each 8-bit register.
`default_nettype none
package vsptc_pkg;
  // Register subaddresses, reset value and unmapped read data.
  localparam logic [7:0] VSPTC_ADDR_PIN_CTRL = 8'h6B;
  localparam logic [7:0] VSPTC_ADDR_HORIZONTAL_TRIGGER_PHASE_LO = 8'h6C;
  localparam logic [7:0] VSPTC_ADDR_TRIG_HI  = 8'h6D;
  localparam logic [7:0] VSPTC_ADDR_BLK_PHS  = 8'h6E;
  localparam logic [7:0] VSPTC_RESET_VALUE   = 8'h00;
  localparam logic [7:0] VSPTC_UNMAPPED_DATA = 8'h00;
  // Fields of sync_pin_control.
  localparam int VSPTC_HPOL_BIT  = 7;
  localparam int VSPTC_HDIR_BIT  = 6;
  localparam int VSPTC_BLANKING_PULSE_SELECT_BIT  = 5;
  localparam int VSPTC_VPOL_BIT  = 4;
  localparam int VSPTC_VDIR_BIT  = 3;
  localparam int VSPTC_HSRC_BIT  = 2;
  localparam int VSPTC_VTYPE_LSB = 0;
  // Fields of trigger_high_and_vertical.
  localparam int VSPTC_HORIZONTAL_TRIGGER_PHASE_HI_LSB = 5;
  localparam int VSPTC_VERTICAL_TRIGGER_PHASE_LSB    = 0;
  // Fields of blanking_and_phase_reset.
  localparam int VSPTC_BLANKING_STANDARD_FORCE_BIT = 7;
  localparam int VSPTC_SUBCARRIER_PHASE_RESET_MODE_LSB = 4;
  localparam int VSPTC_FLC_LSB   = 0;
  // Line lengths in pixel clocks; sync position and length in half pixels.
  localparam logic [10:0] VSPTC_LINE_864  = 11'h360;
  localparam logic [10:0] VSPTC_LINE_858  = 11'h35A;
  localparam logic [10:0] VSPTC_HSYNC_REF = 11'h398;
  localparam logic [10:0] VSPTC_HSYNC_LEN = 11'h040;
  // Half lines per field: 50 Hz and 60 Hz, interlaced / 312 or 262 / 313 or 263 lines.
  localparam logic [9:0] VSPTC_HL50_I  = 10'h271;
  localparam logic [9:0] VSPTC_HL50_S  = 10'h270;
  localparam logic [9:0] VSPTC_HL50_L  = 10'h272;
  localparam logic [9:0] VSPTC_HL60_I  = 10'h20D;
  localparam logic [9:0] VSPTC_HL60_S  = 10'h20C;
  localparam logic [9:0] VSPTC_HL60_L  = 10'h20E;
  localparam logic [9:0] VSPTC_VS_HALF = 10'h006;
  // Standard vertical blanking limits in lines.
  localparam logic [8:0] VSPTC_STD50_FIRST = 9'h017;
  localparam logic [8:0] VSPTC_STD50_LAST  = 9'h136;
  localparam logic [8:0] VSPTC_STD60_FIRST = 9'h014;
  localparam logic [8:0] VSPTC_STD60_LAST  = 9'h106;
  // Signal type of the first reference pin.
  typedef enum logic [1:0] {
    VSPTC_PER_FIELD_VS,
    VSPTC_ODD_EVEN_FS,
    VSPTC_FIELD_SEQ,
    VSPTC_TYPE_BAD
  } vsptc_pin_type_type;
  // Subcarrier phase reset modes.
  typedef enum logic [1:0] {
    VSPTC_PHR_RTC,
    VSPTC_PHR_2LINE,
    VSPTC_PHR_8FLD,
    VSPTC_PHR_4FLD
  } vsptc_phr_type;
endpackage
`default_nettype wire

// ===== logic/vsptc_ref_edge.sv
// Purpose: Synchronise a reference pin and find its active edge.
// Assumes: The pin is asynchronous to i_clk.
// Notes:   o_level is high while the pin is at its active level.
`timescale 1ns/1ns
`default_nettype none
module vsptc_ref_edge (
  input  wire logic i_clk,
  input  wire logic i_reset,
  input  wire logic i_pin,
  input  wire logic i_invert,
  output logic      o_level,
  output logic      o_edge
);
  logic s1_r, s2_r, s3_r;
  logic s1_nxt, s2_nxt, s3_nxt;

  // Two-stage synchroniser plus one history stage.
  always_comb begin
    s1_nxt = i_pin;
    s2_nxt = s1_r;
    s3_nxt = s2_r;
  end

  // Registers of the synchroniser.
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
    end
  end

  // Inverting selects the falling edge as the active one.
  assign o_level = s2_r ^ i_invert;
  assign o_edge  = o_level & ~(s3_r ^ i_invert);
endmodule
`default_nettype wire

// ===== tb/vsptc_src_model.sv
// Purpose: Behavioural video source facing the two reference pins.
// Assumes: No pull resistors on either pin.
// Notes:   A pin that the device drives shows the device level.
`timescale 1ns/1ns
`default_nettype none
module vsptc_src_model (
  input  wire logic i_vreq,
  input  wire logic i_hreq,
  input  wire logic i_vpol,
  input  wire logic i_hpol,
  input  wire logic i_oe1,
  input  wire logic i_dut1,
  input  wire logic i_oe2,
  input  wire logic i_dut2,
  output logic      o_pin1,
  output logic      o_pin2
);
  ////////////////////////////////////////////////////////////////////////////
  // The source pulses at the active level and stays off a driven pin.
  assign o_pin1 = i_oe1 ? i_dut1 : (i_vreq ^ i_vpol);
  assign o_pin2 = i_oe2 ? i_dut2 : (i_hreq ^ i_hpol);
endmodule
`default_nettype wire

// ===== tb/tb_vsptc_top.sv
// Purpose: Self-checking bench for the sync pin and trigger block.
// Assumes: Register port strobes are one-cycle pulses.
// Notes:   Pulse widths and delays are counted in pixel clocks.
`timescale 1ns/1ns
`default_nettype none
module tb_vsptc_top;
  import vsptc_pkg::*;
  logic        clk, rst, reg_wr, reg_rd, lls, realtime_control_enable, realtime_control_input, hreq, hpol, f;
  logic        vreq;
  logic [8:0]  first_active_line, last_active_line;
  logic [7:0]  addr, wdata;
  logic [10:0] pstart, pend;
  wire logic   pin1, pin2, o1, oe1, o2, oe2, hs, blank, phr, va;
  wire logic [7:0] rdata;
  int          err_count, checked, d, w, g, dref;

  ////////////////////////////////////////////////////////////////////////////
  // Device and source model.
  vsptc_top i_vsptc_top (
    .i_clk                     (clk),
    .i_reset                   (rst),
    .i_reg_addr                (addr),
    .i_reg_wr                  (reg_wr),
    .i_reg_rd                  (reg_rd),
    .i_reg_wdata               (wdata),
    .o_reg_rdata               (rdata),
    .i_line_length_select      (lls),
    .i_colour_standard_bit     (1'b1),
    .i_realtime_control_enable (realtime_control_enable),
    .i_realtime_control_input  (realtime_control_input),
    .i_embedded_sync_select    (1'b0),
    .i_embedded_hsync          (1'b0),
    .i_reference_pulse_start   (pstart),
    .i_reference_pulse_end     (pend),
    .i_first_active_line       (first_active_line),
    .i_last_active_line        (last_active_line),
    .i_first_reference_pin     (pin1),
    .o_first_reference_pin     (o1),
    .o_first_reference_pin_oe  (oe1),
    .i_second_reference_pin    (pin2),
    .o_second_reference_pin    (o2),
    .o_second_reference_pin_oe (oe2),
    .o_hsync                   (hs),
    .o_internal_blank          (blank),
    .o_sc_phase_reset          (phr),
    .o_v_alternate             (va),
    .o_odd_field               ()
  );
  vsptc_src_model i_vsptc_src_model (
    .i_vreq (vreq),
    .i_hreq (hreq),
    .i_vpol (1'b0),
    .i_hpol (hpol),
    .i_oe1  (oe1),
    .i_dut1 (o1),
    .i_oe2  (oe2),
    .i_dut2 (o2),
    .o_pin1 (pin1),
    .o_pin2 (pin2)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog.
  always #2 clk = ~clk;
  initial begin
    #200000;
    err_count++;
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare tasks, one for each kind of result.
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_count(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Register port access.
  task automatic reg_write(input logic [7:0] a, input logic [7:0] dat);
    @(posedge clk);
    addr <= a;
    wdata <= dat;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk_byte(rdata, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Pulse one reference pin, then time and measure the horizontal sync.
  task automatic hedge(input logic on_v, output int dly, output int wid);
    dly = 0;
    wid = 0;
    @(posedge clk);
    if (on_v) vreq <= 1'b1;
    else hreq <= 1'b1;
    for (int i = 1; i <= 200; i++) begin
      @(posedge clk);
      if (i == 10) {vreq, hreq} <= 2'b00;
      #1;
      if (hs === 1'b1) begin
        wid++;
        if (dly == 0) dly = i;
      end
    end
  endtask

  // Width of the next whole active pulse on the second pin output.
  task automatic pulse_w(input logic act, output int wid);
    int n;
    n = 0;
    wid = 0;
    while (o2 !== ~act && n < 4000) begin
      @(posedge clk);
      #1 n++;
    end
    while (o2 !== act && n < 4000) begin
      @(posedge clk);
      #1 n++;
    end
    while (o2 === act && n < 4000) begin
      @(posedge clk);
      #1 n++;
      wid++;
    end
  endtask

  // Cycles between two subcarrier phase reset pulses.
  task automatic gap(output int gp);
    int n;
    n = 0;
    while (phr !== 1'b1 && n < 4000) begin
      @(posedge clk);
      #1 n++;
    end
    gp = 0;
    do begin
      @(posedge clk);
      #1 gp++;
    end while (phr !== 1'b1 && gp < 4000);
  endtask

  // Raise the real-time input and look for a phase reset pulse.
  task automatic rtc_try(output logic found);
    found = 1'b0;
    @(posedge clk) realtime_control_input <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      #1;
      if (phr === 1'b1) found = 1'b1;
    end
    @(posedge clk) realtime_control_input <= 1'b0;
  endtask

  // Counts, verdict and end of run.
  task automatic test_done();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    {clk, reg_wr, reg_rd, lls, realtime_control_enable, realtime_control_input, hreq, hpol, vreq} = '0;
    first_active_line = 9'h000;
    last_active_line = 9'h1FF;
    {addr, wdata, err_count, checked} = '0;
    rst = 1'b1;
    pstart = 11'h010;
    pend = 11'h030;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk_bit(oe1, 1'b0);
    chk_bit(oe2, 1'b0);
    reg_read(VSPTC_ADDR_PIN_CTRL, VSPTC_RESET_VALUE);
    reg_read(VSPTC_ADDR_HORIZONTAL_TRIGGER_PHASE_LO, VSPTC_RESET_VALUE);
    reg_read(VSPTC_ADDR_TRIG_HI, VSPTC_RESET_VALUE);
    reg_read(VSPTC_ADDR_BLK_PHS, VSPTC_RESET_VALUE);
    reg_read(8'h6A, VSPTC_UNMAPPED_DATA);
    reg_write(VSPTC_ADDR_HORIZONTAL_TRIGGER_PHASE_LO, 8'hA5);
    reg_write(VSPTC_ADDR_TRIG_HI, 8'h5A);
    reg_write(VSPTC_ADDR_BLK_PHS, 8'hC3);
    reg_write(8'h6F, 8'hFF);
    reg_read(VSPTC_ADDR_HORIZONTAL_TRIGGER_PHASE_LO, 8'hA5);
    reg_read(VSPTC_ADDR_TRIG_HI, 8'h5A);
    reg_read(VSPTC_ADDR_BLK_PHS, 8'hC3);
    reg_read(8'h6F, VSPTC_UNMAPPED_DATA);
    reg_write(VSPTC_ADDR_BLK_PHS, 8'h00);
    reg_write(VSPTC_ADDR_PIN_CTRL, 8'h48);
    chk_bit(oe1, 1'b1);
    chk_bit(oe2, 1'b1);
    reg_read(VSPTC_ADDR_PIN_CTRL, 8'h48);
    // Horizontal trigger from the second pin, phase 398H then 388H.
    reg_write(VSPTC_ADDR_PIN_CTRL, 8'h04);
    reg_write(VSPTC_ADDR_HORIZONTAL_TRIGGER_PHASE_LO, 8'h98);
    reg_write(VSPTC_ADDR_TRIG_HI, 8'h60);
    hedge(1'b0, d, w);
    hedge(1'b0, d, w);
    dref = d;
    chk_count(w, VSPTC_HSYNC_LEN >> 1);
    chk_bit(d >= 4 && d <= 6, 1'b1);
    reg_write(VSPTC_ADDR_HORIZONTAL_TRIGGER_PHASE_LO, 8'h88);
    hedge(1'b0, d, w);
    hedge(1'b0, d, w);
    chk_count(d, dref + 8);
    reg_write(VSPTC_ADDR_HORIZONTAL_TRIGGER_PHASE_LO, 8'h98);
    reg_write(VSPTC_ADDR_PIN_CTRL, 8'h84);
    @(posedge clk) hpol <= 1'b1;
    hedge(1'b0, d, w);
    hedge(1'b0, d, w);
    chk_count(d, dref);
    // First pin as the horizontal source.
    reg_write(VSPTC_ADDR_PIN_CTRL, 8'h00);
    hedge(1'b1, d, w);
    hedge(1'b1, d, w);
    chk_count(d, dref);
    chk_count(w, VSPTC_HSYNC_LEN >> 1);
    // Second pin as output: reference pulse and blanking pulse.
    reg_write(VSPTC_ADDR_PIN_CTRL, 8'h40);
    pulse_w(1'b1, w);
    chk_count(w, (pend - pstart) >> 1);
    reg_write(VSPTC_ADDR_PIN_CTRL, 8'hC0);
    pulse_w(1'b0, w);
    chk_count(w, (pend - pstart) >> 1);
    reg_write(VSPTC_ADDR_PIN_CTRL, 8'h60);
    pulse_w(1'b1, w);
    chk_count(w, (pend - pstart) >> 1);
    @(posedge clk) first_active_line <= 9'h1FF;
    pulse_w(1'b1, w);
    chk_count(w, 0);
    // Two-line phase reset at both line lengths.
    reg_write(VSPTC_ADDR_PIN_CTRL, 8'h00);
    @(posedge clk) hpol <= 1'b0;
    reg_write(VSPTC_ADDR_BLK_PHS, 8'h10);
    gap(g);
    chk_count(g, 2 * VSPTC_LINE_864);
    @(posedge clk) lls <= 1'b1;
    gap(g);
    gap(g);
    chk_count(g, 2 * VSPTC_LINE_858);
    chk_bit(va, 1'b1);
    // Real-time phase reset, enabled and disabled.
    reg_write(VSPTC_ADDR_BLK_PHS, 8'h00);
    @(posedge clk) realtime_control_enable <= 1'b1;
    rtc_try(f);
    chk_bit(f, 1'b1);
    @(posedge clk) realtime_control_enable <= 1'b0;
    rtc_try(f);
    chk_bit(f, 1'b0);
    // Second pin input used as internal blanking.
    reg_write(VSPTC_ADDR_PIN_CTRL, 8'h20);
    @(posedge clk) hreq <= 1'b1;
    repeat (6) @(posedge clk);
    #1 chk_bit(blank, 1'b0);
    @(posedge clk) hreq <= 1'b0;
    repeat (6) @(posedge clk);
    #1 chk_bit(blank, 1'b1);
    test_done();
  end
endmodule
`default_nettype wire
